/* File: ued_dev_end.sv */
// Purpose: endpoint descriptor registers and control OUT byte-count logic
// Assumes: microcontroller register port and link on one clock
// Notes:   control OUT bytes are written to shared buffer ram from E000
`timescale 1ns/1ps
`default_nettype none
module ued_dev_end #(
  parameter int N_EP = ued_pkg::N_EP_DEF
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // link
  ued_if.dev               lnk,
  // microcontroller register port
  input  wire logic [15:0] i_mcu_addr,
  input  wire logic        i_mcu_wr,
  input  wire logic        i_mcu_rd,
  input  wire logic [7:0]  i_mcu_wdata,
  output logic             o_mcu_rvalid,
  output logic [7:0]       o_mcu_rdata,
  // shared buffer ram write
  output logic             o_ram_we,
  output logic [15:0]      o_ram_addr,
  output logic [7:0]       o_ram_wdata
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  generate
    if (N_EP < 1 || N_EP > 4) begin : g_bad
      $error("N_EP must be 1 to 4");
    end
  endgenerate

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {UED_RX_IDLE, UED_RX_TAKE, UED_RX_BUSY, UED_RX_SKIP} ued_rx_t;

  localparam int DEPTH = 64;

  logic [7:0]  mem_q [0:DEPTH-1];
  logic        nak_q;
  logic [6:0]  cnt_q;
  ued_rx_t     rx_q;
  logic [7:0]  rx_cnt_q;
  logic        hs_vld_q, hs_nak_q;
  logic        lk_ack_q;
  logic [7:0]  lk_data_q;
  logic [10:0] lk_count_q;
  logic [15:0] lk_desc_q, lk_buf_q;
  logic        mcu_hit, lk_hit, lk_use_y;
  logic [5:0]  mcu_idx, lk_idx, lk_base_idx, lk_cl_idx, lk_ch_idx;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // endpoint 1..N_EP in the mapped register space
  function automatic logic ep_ok(input logic [2:0] ep);
    ep_ok = (ep != 3'h0) && (ep <= 3'(N_EP));
  endfunction

  // descriptor array index from endpoint, direction and entry
  function automatic logic [5:0] idx_of(input logic [2:0] ep, input logic dir,
                                        input logic [2:0] ent);
    logic [2:0] epm;
    epm    = ep - 3'h1;
    idx_of = {dir, epm[1:0], ent};
  endfunction

  // writable bits of each entry
  function automatic logic [7:0] wmask(input logic [2:0] ent);
    unique case (ent)
      ued_pkg::ENT_CFG:   wmask = ued_pkg::CFG_WMASK;
      ued_pkg::ENT_CNTHX: wmask = ued_pkg::CNTH_WMASK;
      ued_pkg::ENT_CNTHY: wmask = ued_pkg::CNTH_WMASK;
      default:            wmask = 8'hFF;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // descriptor hit: F, five zeros, endpoint, direction, entry
  assign mcu_hit = (i_mcu_addr[15:12] == ued_pkg::MMR_HI) &&
                   (i_mcu_addr[11:7] == 5'h00) && ep_ok(i_mcu_addr[6:4]);
  assign mcu_idx = idx_of(i_mcu_addr[6:4], i_mcu_addr[3], i_mcu_addr[2:0]);

  // lookup decode
  assign lk_hit      = ep_ok(lnk.lk_ep);
  assign lk_idx      = idx_of(lnk.lk_ep, lnk.lk_dir, lnk.lk_entry);
  assign lk_use_y    = lnk.lk_sec &&
                       mem_q[idx_of(lnk.lk_ep, lnk.lk_dir, ued_pkg::ENT_CFG)][ued_pkg::DOUBLE_BUFFER_ENABLE_BIT];
  assign lk_base_idx = idx_of(lnk.lk_ep, lnk.lk_dir,
                              lk_use_y ? ued_pkg::ENT_BASEY : ued_pkg::ENT_BASEX);
  assign lk_cl_idx   = idx_of(lnk.lk_ep, lnk.lk_dir,
                              lk_use_y ? ued_pkg::ENT_CNTLY : ued_pkg::ENT_CNTLX);
  assign lk_ch_idx   = idx_of(lnk.lk_ep, lnk.lk_dir,
                              lk_use_y ? ued_pkg::ENT_CNTHY : ued_pkg::ENT_CNTHX);

  // ----------------------------------------------------------------
  // descriptor registers
  // ----------------------------------------------------------------
  // written only from the microcontroller port; the link has no write path
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_q[k] <= ued_pkg::ENT_RST;
      end
    end else if (i_mcu_wr && mcu_hit) begin
      mem_q[mcu_idx] <= (i_mcu_wdata & wmask(i_mcu_addr[2:0])) |
                        (mem_q[mcu_idx] & ~wmask(i_mcu_addr[2:0]));
    end
  end

  // ----------------------------------------------------------------
  // control_out_count register
  // ----------------------------------------------------------------
  // firmware clears the flow bit; a hardware set in the same cycle wins
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      nak_q <= 1'b0;
      cnt_q <= 7'h00;
    end else begin
      if (i_mcu_wr && (i_mcu_addr == ued_pkg::CTL_OUT_CNT_A)) begin
        nak_q <= i_mcu_wdata[ued_pkg::NAK_BIT];
      end
      if (rx_q == UED_RX_TAKE && lnk.pkt_end && rx_cnt_q <= ued_pkg::CTL_MAX) begin
        nak_q <= 1'b1;
        cnt_q <= rx_cnt_q[6:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // control OUT receive
  // ----------------------------------------------------------------
  // byte counter saturates one past the limit so oversize stays visible
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_q     <= UED_RX_IDLE;
      rx_cnt_q <= 8'h00;
    end else begin
      unique case (rx_q)
        UED_RX_IDLE: begin
          rx_cnt_q <= 8'h00;
          if (lnk.pkt_start) begin
            if (lnk.pkt_ep != ued_pkg::EP_CTL) begin
              rx_q <= UED_RX_SKIP;
            end else if (nak_q) begin
              rx_q <= UED_RX_BUSY;
            end else begin
              rx_q <= UED_RX_TAKE;
            end
          end
        end
        UED_RX_TAKE: begin
          if (lnk.pkt_end) begin
            rx_q <= UED_RX_IDLE;
          end else if (lnk.pkt_vld && rx_cnt_q <= ued_pkg::CTL_MAX) begin
            rx_cnt_q <= rx_cnt_q + 8'h01;
          end
        end
        UED_RX_BUSY: begin
          if (lnk.pkt_end) begin
            rx_q <= UED_RX_IDLE;
          end
        end
        UED_RX_SKIP: begin
          if (lnk.pkt_end) begin
            rx_q <= UED_RX_IDLE;
          end
        end
      endcase
    end
  end

  // handshake: ACK on a legal packet, NAK while full, none when oversize
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hs_vld_q <= 1'b0;
      hs_nak_q <= 1'b0;
    end else begin
      hs_vld_q <= 1'b0;
      if (lnk.pkt_end && rx_q == UED_RX_TAKE && rx_cnt_q <= ued_pkg::CTL_MAX) begin
        hs_vld_q <= 1'b1;
        hs_nak_q <= 1'b0;
      end else if (lnk.pkt_end && rx_q == UED_RX_BUSY) begin
        hs_vld_q <= 1'b1;
        hs_nak_q <= 1'b1;
      end
    end
  end

  // received bytes go into the control OUT buffer only
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ram_we    <= 1'b0;
      o_ram_addr  <= ued_pkg::CTL_OUT_BUF;
      o_ram_wdata <= 8'h00;
    end else begin
      o_ram_we <= 1'b0;
      if (rx_q == UED_RX_TAKE && lnk.pkt_vld && !lnk.pkt_end &&
          rx_cnt_q < ued_pkg::CTL_MAX) begin
        o_ram_we    <= 1'b1;
        o_ram_addr  <= {ued_pkg::CTL_OUT_BUF[15:6], rx_cnt_q[5:0]};
        o_ram_wdata <= lnk.pkt_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // microcontroller read
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mcu_rvalid <= 1'b0;
      o_mcu_rdata  <= 8'h00;
    end else begin
      o_mcu_rvalid <= i_mcu_rd;
      if (i_mcu_rd) begin
        if (mcu_hit) begin
          o_mcu_rdata <= mem_q[mcu_idx];
        end else if (i_mcu_addr == ued_pkg::CTL_OUT_CNT_A) begin
          o_mcu_rdata <= {nak_q, cnt_q};
        end else begin
          o_mcu_rdata <= 8'h00;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // descriptor lookup for the packet side
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lk_ack_q   <= 1'b0;
      lk_data_q  <= 8'h00;
      lk_count_q <= 11'h000;
      lk_desc_q  <= 16'h0000;
      lk_buf_q   <= 16'h0000;
    end else begin
      lk_ack_q <= lnk.lk_req;
      if (lnk.lk_req) begin
        lk_desc_q <= {ued_pkg::MMR_HI, 5'h00, lnk.lk_ep, lnk.lk_dir, 3'h0};
        if (lk_hit) begin
          lk_data_q  <= mem_q[lk_idx];
          lk_count_q <= {mem_q[lk_ch_idx][2:0], mem_q[lk_cl_idx]};
          lk_buf_q   <= {ued_pkg::BUF_HI, mem_q[lk_base_idx], 4'h0};
        end else begin
          lk_data_q  <= 8'h00;
          lk_count_q <= 11'h000;
          lk_buf_q   <= 16'h0000;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------
  assign lnk.hs_vld       = hs_vld_q;
  assign lnk.hs_nak       = hs_nak_q;
  assign lnk.lk_ack       = lk_ack_q;
  assign lnk.lk_data      = lk_data_q;
  assign lnk.lk_count     = lk_count_q;
  assign lnk.lk_desc_addr = lk_desc_q;
  assign lnk.lk_buf_addr  = lk_buf_q;
endmodule
`default_nettype wire

/* File: ued_pkg.sv */
// Purpose: shared constants for the endpoint descriptor block and its link partner
// Assumes: one 8-bit register space addressed by 16-bit XDATA addresses
// Notes:   all numbers used by both ends live here
package ued_pkg;
  // ----------------------------------------------------------------
  // address space
  // ----------------------------------------------------------------
  localparam logic [3:0]  MMR_HI        = 4'hF;     // register space nibble
  localparam logic [3:0]  BUF_HI        = 4'hE;     // buffer ram nibble
  localparam logic [15:0] CTL_OUT_CNT_A = 16'hF004; // control_out_count
  localparam logic [15:0] CTL_OUT_BUF   = 16'hE000; // control OUT buffer start
  localparam logic [15:0] CTL_OUT_END   = 16'hE03F;
  localparam logic [15:0] CTL_IN_BUF    = 16'hE040; // control IN buffer start
  localparam logic [15:0] CTL_IN_END    = 16'hE07F;
  localparam logic [15:0] FREE_BUF      = 16'hE080; // first free byte
  localparam logic [15:0] BUF_TOP       = 16'hEFFF; // buffer_space_top
  // ----------------------------------------------------------------
  // control OUT endpoint
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTL_MAX       = 8'h40;    // 64 bytes
  localparam int          NAK_BIT       = 7;
  // ----------------------------------------------------------------
  // descriptor entries, selected by address bits 2..0
  // ----------------------------------------------------------------
  localparam logic [2:0]  ENT_CFG       = 3'h0;
  localparam logic [2:0]  ENT_BASEX     = 3'h1;
  localparam logic [2:0]  ENT_CNTLX     = 3'h2;
  localparam logic [2:0]  ENT_CNTHX     = 3'h3;
  localparam logic [2:0]  ENT_SIZE      = 3'h4;
  localparam logic [2:0]  ENT_BASEY     = 3'h5;
  localparam logic [2:0]  ENT_CNTLY     = 3'h6;
  localparam logic [2:0]  ENT_CNTHY     = 3'h7;
  localparam logic        DIR_IN        = 1'b0;
  localparam logic        DIR_OUT       = 1'b1;
  localparam int          DOUBLE_BUFFER_ENABLE_BIT      = 4;        // double_buffer_enable
  localparam logic [7:0]  CFG_WMASK     = 8'hDD;    // bit5 and bit1 read-only
  localparam logic [7:0]  CNTH_WMASK    = 8'h87;    // bits 6..3 reserved
  localparam logic [7:0]  ENT_RST       = 8'h00;
  localparam int          N_EP_DEF      = 4;
  // ----------------------------------------------------------------
  // bulk packet limits
  // ----------------------------------------------------------------
  localparam logic [11:0] BULK_MAX_HS   = 12'h200;  // 512 bytes
  localparam logic [11:0] BULK_MAX_FS   = 12'h040;  // 64 bytes
  localparam logic [2:0]  EP_CTL        = 3'h0;
endpackage

/* File: ued_if.sv */
// Purpose: link between the packet side and the endpoint descriptor block
// Assumes: both ends on the same clock
// Notes:   host drives packets and lookups, device answers
`timescale 1ns/1ps
`default_nettype none
interface ued_if;
  // packet stream, host to device
  logic        pkt_start;
  logic [2:0]  pkt_ep;
  logic        pkt_vld;
  logic [7:0]  pkt_byte;
  logic        pkt_end;
  // handshake, device to host
  logic        hs_vld;
  logic        hs_nak;
  // descriptor lookup request
  logic        lk_req;
  logic [2:0]  lk_ep;
  logic        lk_dir;
  logic [2:0]  lk_entry;
  logic        lk_sec;
  // descriptor lookup answer
  logic        lk_ack;
  logic [7:0]  lk_data;
  logic [10:0] lk_count;
  logic [15:0] lk_desc_addr;
  logic [15:0] lk_buf_addr;
  modport dev (
    input  pkt_start, pkt_ep, pkt_vld, pkt_byte, pkt_end,
    input  lk_req, lk_ep, lk_dir, lk_entry, lk_sec,
    output hs_vld, hs_nak,
    output lk_ack, lk_data, lk_count, lk_desc_addr, lk_buf_addr
  );
  modport hst (
    output pkt_start, pkt_ep, pkt_vld, pkt_byte, pkt_end,
    output lk_req, lk_ep, lk_dir, lk_entry, lk_sec,
    input  hs_vld, hs_nak,
    input  lk_ack, lk_data, lk_count, lk_desc_addr, lk_buf_addr
  );
endinterface
`default_nettype wire

/* File: ued_host_end.sv */
// Purpose: packet-side end: forwards packets and lookups, returns answers
// Assumes: user side on the same clock
// Notes:   bulk packets are cut at the speed limit
`timescale 1ns/1ps
`default_nettype none
module ued_host_end (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // link
  ued_if.hst               lnk,
  // packet source
  input  wire logic        i_pkt_start,
  input  wire logic [2:0]  i_pkt_ep,
  input  wire logic        i_pkt_vld,
  input  wire logic [7:0]  i_pkt_byte,
  input  wire logic        i_pkt_end,
  input  wire logic        i_high_speed,
  // handshake result
  output logic             o_hs_vld,
  output logic             o_hs_nak,
  // lookup request
  input  wire logic        i_lk_req,
  input  wire logic [2:0]  i_lk_ep,
  input  wire logic        i_lk_dir,
  input  wire logic [2:0]  i_lk_entry,
  input  wire logic        i_lk_sec,
  // lookup result
  output logic             o_lk_ack,
  output logic [7:0]       o_lk_data,
  output logic [10:0]      o_lk_count,
  output logic [15:0]      o_lk_desc_addr,
  output logic [15:0]      o_lk_buf_addr
);
  logic        start_q, vld_q, end_q, req_q, dir_q, sec_q;
  logic [2:0]  ep_q, lep_q, ent_q;
  logic [7:0]  byte_q;
  logic [11:0] tx_cnt_q;
  logic        limit_hit;

  // bulk byte limit for the current speed
  assign limit_hit = (ep_q != ued_pkg::EP_CTL) &&
                     (tx_cnt_q >= (i_high_speed ? ued_pkg::BULK_MAX_HS
                                                : ued_pkg::BULK_MAX_FS));

  // packet forwarding with bulk truncation
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      start_q  <= 1'b0;
      vld_q    <= 1'b0;
      end_q    <= 1'b0;
      byte_q   <= 8'h00;
      ep_q     <= 3'h0;
      tx_cnt_q <= 12'h000;
    end else begin
      start_q <= i_pkt_start;
      end_q   <= i_pkt_end;
      vld_q   <= 1'b0;
      if (i_pkt_start) begin
        ep_q     <= i_pkt_ep;
        tx_cnt_q <= 12'h000;
      end else if (i_pkt_vld && !limit_hit) begin
        vld_q    <= 1'b1;
        byte_q   <= i_pkt_byte;
        tx_cnt_q <= tx_cnt_q + 12'h001;
      end
    end
  end

  // lookup request forwarding
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      req_q <= 1'b0;
      lep_q <= 3'h0;
      dir_q <= 1'b0;
      ent_q <= 3'h0;
      sec_q <= 1'b0;
    end else begin
      req_q <= i_lk_req;
      if (i_lk_req) begin
        lep_q <= i_lk_ep;
        dir_q <= i_lk_dir;
        ent_q <= i_lk_entry;
        sec_q <= i_lk_sec;
      end
    end
  end

  // answers captured from the link
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hs_vld       <= 1'b0;
      o_hs_nak       <= 1'b0;
      o_lk_ack       <= 1'b0;
      o_lk_data      <= 8'h00;
      o_lk_count     <= 11'h000;
      o_lk_desc_addr <= 16'h0000;
      o_lk_buf_addr  <= 16'h0000;
    end else begin
      o_hs_vld <= lnk.hs_vld;
      o_lk_ack <= lnk.lk_ack;
      if (lnk.hs_vld) begin
        o_hs_nak <= lnk.hs_nak;
      end
      if (lnk.lk_ack) begin
        o_lk_data      <= lnk.lk_data;
        o_lk_count     <= lnk.lk_count;
        o_lk_desc_addr <= lnk.lk_desc_addr;
        o_lk_buf_addr  <= lnk.lk_buf_addr;
      end
    end
  end

  // link drive
  assign lnk.pkt_start = start_q;
  assign lnk.pkt_ep    = ep_q;
  assign lnk.pkt_vld   = vld_q;
  assign lnk.pkt_byte  = byte_q;
  assign lnk.pkt_end   = end_q;
  assign lnk.lk_req    = req_q;
  assign lnk.lk_ep     = lep_q;
  assign lnk.lk_dir    = dir_q;
  assign lnk.lk_entry  = ent_q;
  assign lnk.lk_sec    = sec_q;
endmodule
`default_nettype wire

/* File: ued_sva.sv */
// Purpose: checker for the link between host end and endpoint descriptor end
// Assumes: one clock, reset active low, N_EP endpoints mapped
// Notes:   instantiated beside the link interface in the testbench
`timescale 1ns/1ps
`default_nettype none
module ued_sva #(
  parameter int N_EP = 4
) (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_nrst,
  // packet link
  input wire logic        pkt_start,
  input wire logic [2:0]  pkt_ep,
  input wire logic        pkt_vld,
  input wire logic        pkt_end,
  input wire logic        hs_vld,
  // lookup link
  input wire logic        lk_req,
  input wire logic [2:0]  lk_ep,
  input wire logic        lk_dir,
  input wire logic [2:0]  lk_entry,
  input wire logic        lk_sec,
  input wire logic        lk_ack,
  input wire logic [7:0]  lk_data,
  input wire logic [10:0] lk_count,
  input wire logic [15:0] lk_desc_addr,
  input wire logic [15:0] lk_buf_addr
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic [2:0]  ep_q;
  logic [11:0] cnt_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // endpoint of the open packet
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) ep_q <= 3'h0;
    else if (pkt_start) ep_q <= pkt_ep;
  end
  // bytes seen in the open packet
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) cnt_q <= 12'h000;
    else if (pkt_start) cnt_q <= 12'h000;
    else if (pkt_vld) cnt_q <= cnt_q + 12'h001;
  end
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_ctl_big;
    pkt_end && ep_q == ued_pkg::EP_CTL && cnt_q > 12'h040;
  endsequence
  sequence s_good_ack;
    lk_ack && $past(lk_ep) != 3'h0 && $past(lk_ep) <= N_EP;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_hs_cause: assert property (hs_vld |-> $past(pkt_end) && ep_q == ued_pkg::EP_CTL)
    else $error("handshake without a closing control packet");
  a_big_silent: assert property (s_ctl_big |=> !hs_vld)
    else $error("oversize control packet answered");
  a_hs_pulse: assert property (hs_vld |=> !hs_vld)
    else $error("handshake longer than one cycle");
  a_ack_next: assert property (lk_req |=> lk_ack)
    else $error("lookup not answered next cycle");
  a_ack_cause: assert property (lk_ack |-> $past(lk_req))
    else $error("lookup answer without request");
  a_desc_form: assert property (lk_ack |-> lk_desc_addr ==
    {ued_pkg::MMR_HI, 5'h00, $past(lk_ep), $past(lk_dir), 3'h0})
    else $error("descriptor address badly formed");
  a_buf_form: assert property (s_good_ack |->
    lk_buf_addr[15:12] == ued_pkg::BUF_HI && lk_buf_addr[3:0] == 4'h0)
    else $error("buffer address badly formed");
  a_base_field: assert property (s_good_ack ##0 ($past(lk_entry) == ued_pkg::ENT_BASEX
    && !$past(lk_sec)) |-> lk_buf_addr[11:4] == lk_data)
    else $error("buffer address not built from base entry");
  a_bad_ep: assert property (lk_ack && $past(lk_ep) == 3'h0 |->
    lk_data == 8'h00 && lk_count == 11'h000 && lk_buf_addr == 16'h0000)
    else $error("unmapped endpoint lookup not zero");
  a_bulk_cap: assert property (pkt_vld && ep_q != ued_pkg::EP_CTL |-> cnt_q < 12'h200)
    else $error("bulk packet beyond 512 bytes");
endmodule
`default_nettype wire

/* File: usb_endpoint_descriptor_block_tb.sv */
// Purpose: testbench joining host end and descriptor end through the link
// Assumes: 250 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   register port, packet source and lookup driven by tasks
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_descriptor_block_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk, nrst, pkt_start, pkt_vld, pkt_end, high_speed;
  logic        lk_req, lk_dir, lk_sec, mcu_wr, mcu_rd, got, nak;
  logic        hs_vld, hs_nak, lk_ack, mcu_rvalid, ram_we;
  logic [2:0]  pkt_ep, lk_ep, lk_entry;
  logic [7:0]  pkt_byte, mcu_wdata, lk_data, mcu_rdata, ram_wdata, v;
  logic [10:0] lk_count;
  logic [15:0] mcu_addr, lk_desc_addr, lk_buf_addr, ram_addr;
  int          n_errors, total_checks, cyc, ram_k, lnk_n;
  ued_if lnk ();
  // design ends and checker
  ued_host_end i_ued_host_end (.i_clk(clk), .i_nrst(nrst), .lnk(lnk),
    .i_pkt_start(pkt_start), .i_pkt_ep(pkt_ep), .i_pkt_vld(pkt_vld),
    .i_pkt_byte(pkt_byte), .i_pkt_end(pkt_end), .i_high_speed(high_speed),
    .o_hs_vld(hs_vld), .o_hs_nak(hs_nak), .i_lk_req(lk_req), .i_lk_ep(lk_ep),
    .i_lk_dir(lk_dir), .i_lk_entry(lk_entry), .i_lk_sec(lk_sec), .o_lk_ack(lk_ack),
    .o_lk_data(lk_data), .o_lk_count(lk_count), .o_lk_desc_addr(lk_desc_addr),
    .o_lk_buf_addr(lk_buf_addr));
  ued_dev_end #(.N_EP(4)) i_ued_dev_end (.i_clk(clk), .i_nrst(nrst), .lnk(lnk),
    .i_mcu_addr(mcu_addr), .i_mcu_wr(mcu_wr), .i_mcu_rd(mcu_rd),
    .i_mcu_wdata(mcu_wdata), .o_mcu_rvalid(mcu_rvalid), .o_mcu_rdata(mcu_rdata),
    .o_ram_we(ram_we), .o_ram_addr(ram_addr), .o_ram_wdata(ram_wdata));
  ued_sva #(.N_EP(4)) i_ued_sva (.i_clk(clk), .i_nrst(nrst),
    .pkt_start(lnk.pkt_start), .pkt_ep(lnk.pkt_ep), .pkt_vld(lnk.pkt_vld),
    .pkt_end(lnk.pkt_end), .hs_vld(lnk.hs_vld), .lk_req(lnk.lk_req),
    .lk_ep(lnk.lk_ep), .lk_dir(lnk.lk_dir), .lk_entry(lnk.lk_entry),
    .lk_sec(lnk.lk_sec), .lk_ack(lnk.lk_ack), .lk_data(lnk.lk_data),
    .lk_count(lnk.lk_count), .lk_desc_addr(lnk.lk_desc_addr),
    .lk_buf_addr(lnk.lk_buf_addr));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function logic [15:0] adr(input int ep, input int d, input int e);
    return {ued_pkg::MMR_HI, 5'h00, 3'(ep), 1'(d), 3'(e)};
  endfunction
  function logic [7:0] val(input int ep, input int d, input int e);
    return 8'(ep * 37 + d * 11 + e * 29 + 19);
  endfunction
  function logic [7:0] msk(input int e);
    return (e == 0) ? ued_pkg::CFG_WMASK : (e == 3 || e == 7) ? ued_pkg::CNTH_WMASK : 8'hFF;
  endfunction
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task mcu_w(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk); #1 mcu_addr = a; mcu_wdata = d; mcu_wr = 1'b1;
    @(posedge clk); #1 mcu_wr = 1'b0;
  endtask
  task mcu_r(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk); #1 mcu_addr = a; mcu_rd = 1'b1;
    @(posedge clk); #1 mcu_rd = 1'b0;
    chk("mcu_rvalid", 16'h0001, {15'h0000, mcu_rvalid});
    chk("mcu_rdata", {8'h00, e}, {8'h00, mcu_rdata});
  endtask
  task lookup(input int ep, input int d, input logic [2:0] ent, input logic [7:0] ed,
              input logic [10:0] ec, input int s);
    int n;
    @(posedge clk); #1 lk_ep = 3'(ep); lk_dir = 1'(d); lk_entry = ent; lk_sec = 1'(s);
    lk_req = 1'b1;
    @(posedge clk); #1 lk_req = 1'b0;
    n = 0;
    while (lk_ack !== 1'b1 && n < 8) begin
      @(posedge clk); #1 n++;
    end
    chk("lk_ack", 16'h0001, {15'h0000, lk_ack});
    chk("lk_data", {8'h00, ed}, {8'h00, lk_data});
    chk("lk_count", {5'h00, ec}, {5'h00, lk_count});
    chk("lk_desc_addr", adr(ep, d, 0), lk_desc_addr);
    chk("lk_buf_addr", (ep == 0) ? 16'h0000 : {ued_pkg::BUF_HI, ed, 4'h0}, lk_buf_addr);
  endtask
  task send_pkt(input logic [2:0] ep, input int n);
    ram_k = 0;
    got = 1'b0;
    @(posedge clk); #1 pkt_ep = ep; pkt_start = 1'b1;
    @(posedge clk); #1 pkt_start = 1'b0;
    for (int k = 0; k < n; k++) begin
      pkt_vld = 1'b1; pkt_byte = 8'(k);
      @(posedge clk); #1;
    end
    pkt_vld = 1'b0; pkt_end = 1'b1;
    @(posedge clk); #1 pkt_end = 1'b0;
    repeat (8) begin
      if (hs_vld === 1'b1) begin
        got = 1'b1; nak = hs_nak;
      end
      @(posedge clk); #1;
    end
  endtask
  // ----------------------------------------------------------------
  // clock, timeout and monitors
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // count link and ram traffic on the falling edge, where outputs have settled
  always @(negedge clk) begin
    cyc++;
    if (lnk.pkt_vld === 1'b1) lnk_n++;
    if (ram_we === 1'b1) begin
      chk("ram_addr", 16'(ued_pkg::CTL_OUT_BUF + ram_k), ram_addr);
      chk("ram_wdata", 16'(ram_k[7:0]), {8'h00, ram_wdata});
      ram_k++;
    end
    // cut a hang short
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, pkt_start, pkt_vld, pkt_end, high_speed, lk_req, lk_dir, lk_sec} = '0;
    {mcu_wr, mcu_rd, pkt_ep, lk_ep, lk_entry, pkt_byte, mcu_wdata, mcu_addr} = '0;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    mcu_r(ued_pkg::CTL_OUT_CNT_A, 8'h00);
    mcu_r(16'hF010, 8'h00);
    for (int ep = 1; ep <= 4; ep++) for (int d = 0; d < 2; d++) begin
      for (int e = 0; e < 8; e++) mcu_w(adr(ep, d, e), val(ep, d, e));
      for (int e = 0; e < 8; e++) mcu_r(adr(ep, d, e), val(ep, d, e) & msk(e));
      mcu_w(adr(ep, d, 0), 8'h00);
      v = val(ep, d, 3);
      lookup(ep, d, ued_pkg::ENT_BASEX, val(ep, d, 1), {v[2:0], val(ep, d, 2)}, d);
      mcu_w(adr(ep, d, 0), 8'h10);
      v = val(ep, d, 7);
      lookup(ep, d, ued_pkg::ENT_BASEY, val(ep, d, 5), {v[2:0], val(ep, d, 6)}, 1);
    end
    mcu_w(16'hF050, 8'hFF);
    mcu_r(16'hF050, 8'h00);
    lookup(0, 0, ued_pkg::ENT_BASEX, 8'h00, 11'h000, 0);
    send_pkt(3'h0, 5);
    chk("hs", 16'h0002, {14'h0000, got, nak});
    mcu_r(ued_pkg::CTL_OUT_CNT_A, 8'h85);
    send_pkt(3'h0, 3);
    chk("hs", 16'h0003, {14'h0000, got, nak});
    mcu_r(ued_pkg::CTL_OUT_CNT_A, 8'h85);
    mcu_w(ued_pkg::CTL_OUT_CNT_A, 8'h7F);
    mcu_r(ued_pkg::CTL_OUT_CNT_A, 8'h05);
    send_pkt(3'h0, 65);
    chk("hs_got", 16'h0000, {15'h0000, got});
    chk("ram_count", 16'h0040, 16'(ram_k));
    mcu_r(ued_pkg::CTL_OUT_CNT_A, 8'h05);
    send_pkt(3'h0, 64);
    chk("hs", 16'h0002, {14'h0000, got, nak});
    mcu_r(ued_pkg::CTL_OUT_CNT_A, 8'hC0);
    lnk_n = 0;
    send_pkt(3'h1, 70);
    chk("bulk_fs", 16'h0040, 16'(lnk_n));
    high_speed = 1'b1;
    lnk_n = 0;
    send_pkt(3'h2, 600);
    chk("bulk_hs", 16'h0200, 16'(lnk_n));
    end_sim();
  end
endmodule
`default_nettype wire
